/* hdl/dccf_pkg.sv */
// Constants and carrier types of one DMA channel's control fields
// Contract
// - Checksum observe feeds every transfer to checksum
// - Observe only when checksum unit selects channel
// - Quiet mode: interrupt only on zero trigger
// - Pacing values up to 0x3A pick peripheral
// - Values 0x3B to 0x3E pick timers 0-3
// - Value 0x3F means always requesting
// - Completion triggers the next linked channel
// - Link equal own number disables chaining
// - Wrap target bit picks read or write
// - Wrap size n keeps low n bits changing
// - Ring sizes 2 to 32768 bytes supported
// - Write step advances write address
// - Read step advances read address
// - Width field picks byte, halfword, word
// - Preferred channels first, then one ordinary
// - Preference never changes system bus priority
// - Enabled channel accepts triggers, goes busy
// - Disabled channel ignores triggers, pauses, stays busy
// - Control alias at channel offset 0x010
// - Busy rises at start, falls at end
// - Trigger copies reload into live counter
// - Nonzero trigger write starts, zero does not
package dccf_pkg;
	localparam logic [5:0] OFS_READ_ADDR = 6'h00;
	localparam logic [5:0] OFS_WRITE_ADDR = 6'h04;
	localparam logic [5:0] OFS_TRANSFER_COUNTER = 6'h08;
	localparam logic [5:0] OFS_CTRL_TRIG = 6'h0C;
	localparam logic [5:0] OFS_CTRL_ALIAS_ONE = 6'h10;
	localparam logic [5:0] OFS_COUNT_TRIG_ALIAS = 6'h1C;
	localparam int BUSY_BIT = 24;
	localparam int FIELD_BITS = 24;
	localparam logic [5:0] PACE_LAST_PERIPH = 6'h3A;
	localparam logic [5:0] PACE_TIMER0 = 6'h3B;
	localparam logic [5:0] PACE_ALWAYS = 6'h3F;
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [31:0] ADDR_RESET = 32'h00000000;
	localparam logic [31:0] COUNT_RESET = 32'h00000000;

	// Field layout of control bits 23..0
	typedef struct packed {
		logic checksum_observe;
		logic byte_reverse;
		logic quiet_irq;
		logic [5:0] pacing_source;
		logic [3:0] next_channel_link;
		logic wrap_write;
		logic [3:0] wrap_size;
		logic write_step;
		logic read_step;
		logic [1:0] width;
		logic preferred;
		logic enable;
	} dccf_ctrl_s;

	typedef struct packed {
		logic [31:0] addr;
		logic [1:0] size;
		logic [31:0] data;
	} dccf_bus_s;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ASK = 2'b01,
		ST_READ = 2'b10,
		ST_WRITE = 2'b11
	} dccf_state_e;
endpackage : dccf_pkg

/* hdl/dccf_byte_swap.sv */
// Byte order transform applied to transfer data
`timescale 1ns/1ps
`default_nettype none
module dccf_byte_swap
	import dccf_pkg::*;
(
	input wire logic [31:0] data_in,
	input wire logic [1:0] size,
	input wire logic swap,
	output logic [31:0] data_out
);
	always_comb
	begin
		data_out = data_in;
		if (swap && size == SIZE_HALF)
		begin
			data_out = {16'h0000, data_in[7:0], data_in[15:8]};
		end
		else if (swap && size == SIZE_WORD)
		begin
			data_out = {data_in[7:0], data_in[15:8], data_in[23:16], data_in[31:24]};
		end
	end
endmodule : dccf_byte_swap
`default_nettype wire

/* hdl/dccf_addr_step.sv */
// Next address of one stream: step by width, optional ring wrap
`timescale 1ns/1ps
`default_nettype none
module dccf_addr_step
	import dccf_pkg::*;
(
	input wire logic [31:0] addr,
	input wire logic step,
	input wire logic [1:0] size,
	input wire logic wrap,
	input wire logic [3:0] wrap_size,
	output logic [31:0] next_addr
);
	logic [31:0] inc;
	logic [31:0] sum;
	logic [31:0] mask;

	always_comb
	begin
		// step of 1, 2 or 4 bytes
		unique case (size)
			SIZE_HALF: inc = 32'h00000002;
			SIZE_WORD: inc = 32'h00000004;
			default: inc = 32'h00000001;
		endcase
		sum = addr + inc;
		// sizes 1..15 give 2..32768 byte rings
		mask = (32'h00000001 << wrap_size) - 32'h00000001;
		next_addr = addr;
		if (step)
		begin
			next_addr = sum;
			// only the low n bits change
			if (wrap && wrap_size != 4'h0)
			begin
				next_addr = (addr & ~mask) | (sum & mask);
			end
		end
	end
endmodule : dccf_addr_step
`default_nettype wire

/* hdl/dccf_channel.sv */
// One DMA channel: control fields, register port, transfer sequencer
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module dccf_channel
	import dccf_pkg::*;
#(
	parameter logic [3:0] CHAN_ID = 4'h0
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic [58:0] peripheral_data_request,
	input wire logic [3:0] timer_pace,
	input wire logic chain_trigger_in,
	input wire logic sched_grant,
	output logic sched_request,
	output logic sched_preferred,
	output logic rd_req,
	output logic wr_req,
	output dccf_bus_s bus_cmd,
	input wire logic rd_ack,
	input wire logic [31:0] rd_data,
	input wire logic wr_ack,
	input wire logic sniff_enable,
	input wire logic [3:0] sniff_channel,
	output logic sniff_strobe,
	output logic [31:0] sniff_data,
	output logic chain_trigger_out,
	output logic [3:0] chain_target,
	output logic irq_event,
	output logic busy
);
	////////////////////////////////////////////////////////////////
	// State
	dccf_state_e state, next_state;
	dccf_ctrl_s ctrl, next_ctrl;
	logic [31:0] read_addr, next_read_addr;
	logic [31:0] write_addr, next_write_addr;
	logic [31:0] reload, next_reload;
	logic [31:0] count, next_count;
	logic next_busy;
	logic next_sched_request;
	logic next_rd_req;
	logic next_wr_req;
	dccf_bus_s next_bus_cmd;
	logic next_sniff_strobe;
	logic [31:0] next_sniff_data;
	logic next_chain_trigger_out;
	logic next_irq_event;
	logic [31:0] next_reg_rdata;

	////////////////////////////////////////////////////////////////
	// Decode and helpers
	logic hit;
	logic [5:0] offset;
	logic wr_ctrl_trig;
	logic wr_ctrl_alias;
	logic wr_count_trig;
	logic trigger;
	logic [31:0] trigger_count;
	logic pace_ok;
	logic [31:0] stepped_read;
	logic [31:0] stepped_write;
	logic [31:0] swapped;
	logic finishing;

	assign hit = reg_addr[11:6] == {2'b00, CHAN_ID};
	assign offset = reg_addr[5:0];
	assign wr_ctrl_trig = reg_write && hit && offset == OFS_CTRL_TRIG;
	assign wr_ctrl_alias = reg_write && hit && offset == OFS_CTRL_ALIAS_ONE;
	assign wr_count_trig = reg_write && hit && offset == OFS_COUNT_TRIG_ALIAS;

	// read stream wraps when bit clear
	dccf_addr_step u_read_step (
		.addr(read_addr),
		.step(ctrl.read_step),
		.size(ctrl.width),
		.wrap(!ctrl.wrap_write),
		.wrap_size(ctrl.wrap_size),
		.next_addr(stepped_read)
	);

	// Write stream wraps when the bit is set
	dccf_addr_step u_write_step (
		.addr(write_addr),
		.step(ctrl.write_step),
		.size(ctrl.width),
		.wrap(ctrl.wrap_write),
		.wrap_size(ctrl.wrap_size),
		.next_addr(stepped_write)
	);

	dccf_byte_swap u_swap (
		.data_in(rd_data),
		.size(ctrl.width),
		.swap(ctrl.byte_reverse),
		.data_out(swapped)
	);

	////////////////////////////////////////////////////////////////
	// Pacing request selection
	always_comb
	begin
		if (ctrl.pacing_source <= PACE_LAST_PERIPH)
		begin
			pace_ok = peripheral_data_request[ctrl.pacing_source];
		end
		else if (ctrl.pacing_source == PACE_ALWAYS)
		begin
			pace_ok = 1'b1;
		end
		else
		begin
			pace_ok = timer_pace[2'(ctrl.pacing_source - PACE_TIMER0)];
		end
	end

	////////////////////////////////////////////////////////////////
	// Trigger sources
	always_comb
	begin
		trigger_count = reload;
		// only a nonzero count write starts
		if (wr_count_trig && reg_wdata != 32'h00000000)
		begin
			trigger_count = reg_wdata;
		end
		// alias write is absent from this term
		trigger = wr_ctrl_trig || chain_trigger_in
			|| (wr_count_trig && reg_wdata != 32'h00000000);
	end

	////////////////////////////////////////////////////////////////
	// Sequencer and register next values
	always_comb
	begin
		next_state = state;
		next_ctrl = ctrl;
		next_read_addr = read_addr;
		next_write_addr = write_addr;
		next_reload = reload;
		next_count = count;
		next_busy = busy;
		next_sched_request = sched_request;
		next_rd_req = rd_req;
		next_wr_req = wr_req;
		next_bus_cmd = bus_cmd;
		next_sniff_strobe = 1'b0;
		next_sniff_data = sniff_data;
		next_chain_trigger_out = 1'b0;
		next_irq_event = 1'b0;
		finishing = 1'b0;

		unique case (state)
			ST_IDLE:
			begin
				// disabled: no new transfer, busy held
				if (busy && ctrl.enable)
				begin
					if (count == 32'h00000000)
					begin
						finishing = 1'b1;
					end
					else if (pace_ok)
					begin
						// class passed to the round scheduler
						next_sched_request = 1'b1;
						next_state = ST_ASK;
					end
				end
			end
			ST_ASK:
			begin
				if (!ctrl.enable)
				begin
					next_sched_request = 1'b0;
					next_state = ST_IDLE;
				end
				else if (sched_grant)
				begin
					next_sched_request = 1'b0;
					next_rd_req = 1'b1;
					next_bus_cmd = '{addr: read_addr, size: ctrl.width, data: 32'h00000000};
					next_state = ST_READ;
				end
			end
			ST_READ:
			begin
				if (rd_ack)
				begin
					next_rd_req = 1'b0;
					next_wr_req = 1'b1;
					next_bus_cmd = '{addr: write_addr, size: ctrl.width, data: swapped};
					next_state = ST_WRITE;
				end
			end
			ST_WRITE:
			begin
				if (wr_ack)
				begin
					next_wr_req = 1'b0;
					next_read_addr = stepped_read;
					next_write_addr = stepped_write;
					next_count = count - 32'h00000001;
					// sniff gated by checksum unit selection
					if (ctrl.checksum_observe && sniff_enable && sniff_channel == CHAN_ID)
					begin
						next_sniff_strobe = 1'b1;
						next_sniff_data = bus_cmd.data;
					end
					finishing = count == 32'h00000001;
					next_state = ST_IDLE;
				end
			end
		endcase

		if (finishing)
		begin
			// busy falls with the last transfer
			next_busy = 1'b0;
			next_irq_event = !ctrl.quiet_irq;
			next_chain_trigger_out = ctrl.next_channel_link != CHAN_ID;
		end

		// Software writes last so they win over stepping
		if (reg_write && hit)
		begin
			unique case (offset)
				OFS_READ_ADDR: next_read_addr = reg_wdata;
				OFS_WRITE_ADDR: next_write_addr = reg_wdata;
				OFS_TRANSFER_COUNTER: next_reload = reg_wdata;
				OFS_CTRL_TRIG, OFS_CTRL_ALIAS_ONE:
					next_ctrl = dccf_ctrl_s'(reg_wdata[FIELD_BITS-1:0]);
				OFS_COUNT_TRIG_ALIAS: next_reload = reg_wdata;
				default:
				begin
				end
			endcase
		end

		// zero to either trigger register ends a chain
		// Old quiet bit decides, so a zero control write still reports
		if ((wr_ctrl_trig || wr_count_trig) && reg_wdata == 32'h00000000 && ctrl.quiet_irq)
		begin
			next_irq_event = 1'b1;
		end

		// trigger accepted only when enabled and idle
		if (trigger && next_ctrl.enable && !busy)
		begin
			next_count = trigger_count;
			next_busy = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read port: data in the cycle after the strobe
	always_comb
	begin
		next_reg_rdata = 32'h00000000;
		if (reg_read && hit)
		begin
			unique case (offset)
				OFS_READ_ADDR: next_reg_rdata = read_addr;
				OFS_WRITE_ADDR: next_reg_rdata = write_addr;
				OFS_TRANSFER_COUNTER, OFS_COUNT_TRIG_ALIAS: next_reg_rdata = count;
				// both offsets show the same contents
				OFS_CTRL_TRIG, OFS_CTRL_ALIAS_ONE:
				begin
					next_reg_rdata[FIELD_BITS-1:0] = ctrl;
					next_reg_rdata[BUSY_BIT] = busy;
				end
				default: next_reg_rdata = 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= ST_IDLE;
			ctrl <= '{next_channel_link: CHAN_ID, default: '0};
			read_addr <= ADDR_RESET;
			write_addr <= ADDR_RESET;
			reload <= COUNT_RESET;
			count <= COUNT_RESET;
			busy <= 1'b0;
			sched_request <= 1'b0;
			rd_req <= 1'b0;
			wr_req <= 1'b0;
			bus_cmd <= '0;
			sniff_strobe <= 1'b0;
			sniff_data <= 32'h00000000;
			chain_trigger_out <= 1'b0;
			irq_event <= 1'b0;
			reg_rdata <= 32'h00000000;
			sched_preferred <= 1'b0;
			chain_target <= 4'h0;
		end
		else
		begin
			state <= next_state;
			ctrl <= next_ctrl;
			read_addr <= next_read_addr;
			write_addr <= next_write_addr;
			reload <= next_reload;
			count <= next_count;
			busy <= next_busy;
			sched_request <= next_sched_request;
			rd_req <= next_rd_req;
			wr_req <= next_wr_req;
			bus_cmd <= next_bus_cmd;
			sniff_strobe <= next_sniff_strobe;
			sniff_data <= next_sniff_data;
			chain_trigger_out <= next_chain_trigger_out;
			irq_event <= next_irq_event;
			reg_rdata <= next_reg_rdata;
			// issue order only; bus side carries no priority
			sched_preferred <= next_ctrl.preferred;
			chain_target <= next_ctrl.next_channel_link;
		end
	end
endmodule : dccf_channel
`default_nettype wire

/* verification/dccf_checker.sv */
// Assertion checker bound to one DMA channel
`timescale 1ns/1ps
`default_nettype none
module dccf_checker
	import dccf_pkg::*;
#(
	parameter logic [3:0] CHAN_ID = 4'h0
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic chain_trigger_in,
	input wire logic sched_grant,
	input wire logic sched_request,
	input wire logic rd_req,
	input wire logic wr_req,
	input wire logic rd_ack,
	input wire logic wr_ack,
	input wire dccf_bus_s bus_cmd,
	input wire logic sniff_enable,
	input wire logic [3:0] sniff_channel,
	input wire logic sniff_strobe,
	input wire logic [31:0] sniff_data,
	input wire logic chain_trigger_out,
	input wire logic [3:0] chain_target,
	input wire logic irq_event,
	input wire logic busy
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!resetn);
	////////////////////////
	property p_rd_hold; rd_req && !rd_ack |=> rd_req && $stable(bus_cmd.addr); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("rd hold");
	property p_rd_wr; rd_req && rd_ack |=> !rd_req && wr_req; endproperty
	a_rd_wr: assert property (p_rd_wr) else $error("rd to wr");
	property p_grant; sched_request && sched_grant |=> rd_req; endproperty
	a_grant: assert property (p_grant) else $error("grant");
	property p_busy_rise; $rose(busy) |-> $past(reg_write || chain_trigger_in); endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy rise");
	property p_sn_cause; sniff_strobe |-> $past(wr_ack && sniff_enable && sniff_channel == CHAN_ID);
	endproperty
	a_sn_cause: assert property (p_sn_cause) else $error("sniff cause");
	property p_sn_data; sniff_strobe |-> sniff_data == $past(bus_cmd.data); endproperty
	a_sn_data: assert property (p_sn_data) else $error("sniff data");
	property p_chain_end; chain_trigger_out |-> $fell(busy); endproperty
	a_chain_end: assert property (p_chain_end) else $error("chain end");
	property p_chain_self; chain_trigger_out |-> chain_target != CHAN_ID; endproperty
	a_chain_self: assert property (p_chain_self) else $error("chain self");
	property p_rdata; !$past(reg_read) |-> reg_rdata == 32'h0; endproperty
	a_rdata: assert property (p_rdata) else $error("rdata idle");
	c_chain: cover property (chain_trigger_out);
	c_sniff: cover property (sniff_strobe);
	c_irq: cover property (irq_event && !busy);
endmodule : dccf_checker
bind dccf_channel dccf_checker #(.CHAN_ID(CHAN_ID)) i_chk (.clock(clock), .resetn(resetn),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.chain_trigger_in(chain_trigger_in), .sched_grant(sched_grant),
	.sched_request(sched_request), .rd_req(rd_req), .wr_req(wr_req), .rd_ack(rd_ack),
	.wr_ack(wr_ack), .bus_cmd(bus_cmd), .sniff_enable(sniff_enable),
	.sniff_channel(sniff_channel), .sniff_strobe(sniff_strobe), .sniff_data(sniff_data),
	.chain_trigger_out(chain_trigger_out), .chain_target(chain_target),
	.irq_event(irq_event), .busy(busy));
`default_nettype wire

/* verification/dccf_bus_model.sv */
// Bus fabric and scheduler model facing one DMA channel
`timescale 1ns/1ps
`default_nettype none
module dccf_bus_model
	import dccf_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic [3:0] lag,
	input wire logic sched_request,
	input wire logic rd_req,
	input wire logic wr_req,
	input wire dccf_bus_s bus_cmd,
	output logic sched_grant,
	output logic rd_ack,
	output logic wr_ack,
	output logic [31:0] rd_data,
	output logic [31:0] wa,
	output logic [31:0] wd
);
	logic [3:0] cnt;
	// Read data toggles when idle so a stale sample never matches
	always @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			{sched_grant, rd_ack, wr_ack, cnt, rd_data, wa, wd} <= '0;
		end
		else
		begin
			{sched_grant, rd_ack, wr_ack, cnt} <= '0;
			rd_data <= ~rd_data;
			if (!(sched_grant || rd_ack || wr_ack) && (sched_request || rd_req || wr_req))
			begin
				cnt <= cnt + 4'h1;
				if (cnt == lag)
				begin
					cnt <= 4'h0;
					rd_ack <= rd_req;
					wr_ack <= wr_req && !rd_req;
					sched_grant <= sched_request && !rd_req && !wr_req;
					if (rd_req)
						rd_data <= 32'h12345678 ^ bus_cmd.addr;
					if (wr_req && !rd_req)
						{wa, wd} <= {bus_cmd.addr, bus_cmd.data};
				end
			end
		end
	end
endmodule : dccf_bus_model
`default_nettype wire

/* verification/tb.sv */
// Self-checking bench of one DMA channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
	$display("unexpected %0t: %h want %h", $time, a, b); end end
module tb
	import dccf_pkg::*;
;
	localparam logic [3:0] ID = 4'h2;
	localparam logic [5:0] PV [4] = '{6'h05, 6'h3A, 6'h3B, 6'h3E};
	logic clock = 1'h0, resetn = 1'h0, reg_write = 1'h0, reg_read = 1'h0;
	logic chain_trigger_in = 1'h0, sniff_enable = 1'h1;
	logic [11:0] reg_addr = 12'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_data, wa, wd, m, sniff_data;
	logic [58:0] peripheral_data_request = '0;
	logic [3:0] timer_pace = 4'h0, sniff_channel = ID, lag = 4'h0, chain_target;
	logic sched_grant, sched_request, sched_preferred, rd_req, wr_req, rd_ack, wr_ack;
	logic sniff_strobe, chain_trigger_out, irq_event, busy;
	dccf_bus_s bus_cmd;
	int error_cnt = 0, checks_done = 0, n_irq = 0, n_ch = 0, n_sn = 0, i;
	dccf_channel #(.CHAN_ID(ID)) i_dut (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write,
		.reg_read, .reg_rdata, .peripheral_data_request, .timer_pace, .chain_trigger_in,
		.sched_grant, .sched_request, .sched_preferred, .rd_req, .wr_req, .bus_cmd, .rd_ack,
		.rd_data, .wr_ack, .sniff_enable, .sniff_channel, .sniff_strobe, .sniff_data,
		.chain_trigger_out, .chain_target, .irq_event, .busy);
	dccf_bus_model i_bus (.clock, .resetn, .lag, .sched_request, .rd_req, .wr_req,
		.bus_cmd, .sched_grant, .rd_ack, .wr_ack, .rd_data, .wa, .wd);
	always #10 clock = ~clock;
	////////////////////////
	function automatic logic [31:0] ctl(input int s, input logic [5:0] p, input logic [3:0] l,
		input logic q);
		return {8'h00, 2'h3, q, p, l, 5'h00, 2'h2, s[1:0], 2'h3};
	endfunction : ctl
	function automatic logic [31:0] sw(input logic [31:0] d, input int s);
		return s == 2 ? {d[7:0], d[15:8], d[23:16], d[31:24]}
			: s == 1 ? {d[31:16], d[7:0], d[15:8]} : d;
	endfunction : sw
	task automatic wr(input logic [5:0] o, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= {2'h0, ID, o};
		reg_wdata <= d;
		reg_write <= 1'h1;
		@(posedge clock);
		reg_write <= 1'h0;
	endtask : wr
	task automatic rd(input logic [5:0] o, input logic [31:0] e);
		@(posedge clock);
		reg_addr <= {2'h0, ID, o};
		reg_read <= 1'h1;
		@(posedge clock);
		reg_read <= 1'h0;
		@(negedge clock);
		`CHK(reg_rdata, e)
		@(posedge clock);
	endtask : rd
	task automatic pulse();
		@(posedge clock);
		chain_trigger_in <= 1'h1;
		@(posedge clock);
		chain_trigger_in <= 1'h0;
	endtask : pulse
	task automatic wrap_up();
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	// Bounded wait for the sequence to finish
	task automatic done();
		@(negedge clock);
		for (i = 0; i < 300 && busy !== 1'h0; i++)
			@(negedge clock);
		if (busy !== 1'h0)
		begin
			error_cnt++;
			$display("unexpected %0t: busy stuck", $time);
			wrap_up();
		end
	endtask : done
	task automatic xfer(input logic [31:0] n, input logic [31:0] c);
		wr(6'h00, 32'h100);
		wr(6'h04, 32'h200);
		wr(6'h08, n);
		wr(6'h0C, c);
		done();
	endtask : xfer
	always @(negedge clock)
	begin
		n_irq += int'(irq_event === 1'h1);
		n_sn += int'(sniff_strobe === 1'h1);
		if (chain_trigger_out === 1'h1)
		begin
			n_ch++;
			`CHK(chain_target, 4'h5)
		end
	end
	////////////////////////
	initial
	begin
		repeat (10) @(posedge clock);
		resetn <= 1'h1;
		rd(6'h0C, {17'h0, ID, 11'h0});
		rd(6'h20, 32'h0);
		// Width sweep, lag 0 to 4 covers prompt and slow fabric
		for (int s = 0; s < 3; s++)
		begin
			lag <= 4'(s * 2);
			// Middle run: checksum unit off; last run: other channel selected
			sniff_enable <= s != 1;
			sniff_channel <= s == 2 ? 4'h7 : ID;
			xfer(32'h2, ctl(s, 6'h3F, 4'h5, 1'h0));
			m = 32'hFFFFFFFF >> (32 - (8 << s));
			`CHK(wa, 32'h200 + (1 << s))
			`CHK(bus_cmd.size, 2'(s))
			`CHK(wd & m, sw(32'h12345778, s) & m)
			rd(6'h00, 32'h100);
			rd(6'h04, 32'h200 + (2 << s));
		end
		rd(6'h10, ctl(2, 6'h3F, 4'h5, 1'h0));
		@(negedge clock);
		`CHK(sched_preferred, 1'h1)
		// 8-byte read ring: third read wraps back
		xfer(32'h3, ctl(2, 6'h3F, 4'h5, 1'h0) | 32'hD0);
		rd(6'h00, 32'h104);
		// 2-byte write ring of bytes: third write lands on the base
		xfer(32'h3, ctl(0, 6'h3F, 4'h5, 1'h0) | 32'h440);
		`CHK(wa, 32'h200)
		rd(6'h04, 32'h201);
		rd(6'h00, 32'h100);
		`CHK(n_sn, 2)
		foreach (PV[k])
		begin
			wr(6'h08, 32'h1);
			peripheral_data_request <= '0;
			timer_pace <= 4'h0;
			wr(6'h0C, ctl(2, PV[k], ID, 1'h0));
			rd(6'h08, 32'h1);
			repeat (6) @(negedge clock);
			`CHK(sched_request, 1'h0)
			wr(6'h10, ctl(2, PV[k], ID, 1'h0) & ~32'h1);
			if (PV[k] <= PACE_LAST_PERIPH)
				peripheral_data_request[PV[k]] <= 1'h1;
			else
				timer_pace[PV[k] - PACE_TIMER0] <= 1'h1;
			repeat (6) @(negedge clock);
			`CHK({busy, sched_request}, 2'h2)
			wr(6'h10, ctl(2, PV[k], ID, 1'h0));
			done();
		end
		`CHK(n_ch, 5)
		wr(6'h10, ctl(2, 6'h3F, ID, 1'h1) & ~32'h1);
		wr(6'h1C, 32'h1);
		pulse();
		wr(6'h10, ctl(2, 6'h3F, ID, 1'h1));
		repeat (4) @(negedge clock);
		`CHK(busy, 1'h0)
		pulse();
		done();
		wr(6'h1C, 32'h1);
		done();
		`CHK(n_irq, 9)
		wr(6'h1C, 32'h0);
		repeat (2) @(negedge clock);
		`CHK({busy, n_irq == 10}, 2'h1)
		wr(6'h0C, 32'h0);
		repeat (2) @(negedge clock);
		`CHK({busy, n_irq == 11}, 2'h1)
		wrap_up();
	end
endmodule : tb
`default_nettype wire
